// *** pmcd_pkg.sv ***
/*
 * Package for the power mode and clock divider block: register map,
 * control field positions, reset values, timing counts and carriers.
 * Assumes a single 10 MHz reference clock and a synchronous reset.
 */
`default_nettype none

package pmcd_pkg;

    // Register offsets
    localparam logic [7:0] PMCD_POWER_CONTROL_ADDR        = 8'h87;
    localparam logic [7:0] PMCD_SYSTEM_CLOCK_DIVIDER_ADDR = 8'h97;
    localparam logic [7:0] PMCD_WAKE_ENABLE_ADDR          = 8'h98;

    // Power control fields
    localparam int PMCD_BIT_SLEEP      = 0;
    localparam int PMCD_BIT_PDOWN      = 1;
    localparam int PMCD_BIT_GF0        = 2;
    localparam int PMCD_BIT_GF1        = 3;
    localparam int PMCD_BIT_POWER_ON   = 4;
    localparam int PMCD_BIT_LOW_VOLT   = 5;
    localparam int PMCD_BIT_FRAME_SEL  = 6;
    localparam int PMCD_BIT_BAUD_DBL   = 7;

    // Wake enable fields
    localparam int PMCD_BIT_PCA_IDLE_RUN = 0;

    // Reset values
    localparam logic [7:0] PMCD_POWER_CONTROL_RESET = 8'h10;
    localparam logic [2:0] PMCD_DIVIDE_RESET        = 3'h0;
    localparam logic [7:0] PMCD_WAKE_ENABLE_RESET   = 8'h00;

    // Timing
    localparam int PMCD_CLOCK_HZ         = 10_000_000;
    localparam int PMCD_WAKE_OSC_CLOCKS  = 32768;
    localparam int PMCD_IDLE_RESET_OSC   = 24;
    localparam int PMCD_IDLE_RESET_CYC   = (PMCD_IDLE_RESET_OSC < 1) ? 1 : PMCD_IDLE_RESET_OSC;
    localparam int PMCD_DIV_MAX_CODE     = 7;

    // Wake pin bundle
    typedef struct packed {
        logic external_interrupt_a;
        logic external_interrupt_b;
        logic timer_a_input_pin;
        logic timer_b_input_pin;
        logic serial_receive;
        logic capture_input_a;
        logic capture_input_b;
        logic voltage_detect_pin;
    } pmcd_wake_pins_s;

    // Clock gate outputs
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic pca_clk_en;
        logic ext_int_active;
    } pmcd_gates_s;

    typedef enum logic [1:0] {
        PMCD_RUN,
        PMCD_IDLE,
        PMCD_PDOWN,
        PMCD_WAKING
    } pmcd_mode_e;

endpackage

`default_nettype wire

// *** pmcd_power_mode_clock_divider.sv ***
/*
 * Power mode control and system clock divider.
 * Registers reached over a plain strobe port; read data one cycle later.
 * Pin inputs are asynchronous and pass two flops before use.
 * Divided clock is delivered as a one-cycle enable on the reference clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pmcd_power_mode_clock_divider
    import pmcd_pkg::*;
#(
    parameter int WAKE_CLOCKS = PMCD_WAKE_OSC_CLOCKS
) (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    input  wire pmcd_wake_pins_s wake_pins,
    input  wire logic            timer_a_irq,
    input  wire logic            timer_b_irq,
    input  wire logic            uart_irq,
    input  wire logic            enabled_irq,
    input  wire logic            low_voltage_detect,
    input  wire logic            power_on_event,
    output logic                 sys_clk_en,
    output pmcd_gates_s          gates,
    output logic                 uart_baud_doubler,
    output logic                 frame_error_select,
    output logic                 idle_reset_done,
    output pmcd_mode_e           mode
);

    localparam logic [15:0] WAKE_LAST = 16'(WAKE_CLOCKS - 1);
    localparam logic [4:0]  IDLE_RST_LAST = 5'(PMCD_IDLE_RESET_CYC - 1);

    // Two-flop synchronisers for all asynchronous inputs
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync_a_reg;
    logic [NSYNC-1:0] sync_b_reg;
    assign async_in = {wake_pins, low_voltage_detect, power_on_event};
    // Pins idle high, detector levels idle low, so leaving reset sets no flag
    localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h3FC;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    sync_a_reg[gi] <= SYNC_IDLE[gi];
                    sync_b_reg[gi] <= SYNC_IDLE[gi];
                end else begin
                    sync_a_reg[gi] <= async_in[gi];
                    sync_b_reg[gi] <= sync_a_reg[gi];
                end
            end
        end
    endgenerate

    logic [7:0] pins_s;
    logic       lvd_s;
    logic       pon_s;
    logic [7:0] pins_prev_reg;
    logic       pin_activity;
    assign pins_s = sync_b_reg[NSYNC-1:2];
    assign lvd_s  = sync_b_reg[1];
    assign pon_s  = sync_b_reg[0];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pins_prev_reg <= 8'hFF;
        end else begin
            pins_prev_reg <= pins_s;
        end
    end

    // Falling edge on any wake pin
    assign pin_activity = |(pins_prev_reg & ~pins_s);

    // Registers
    logic [7:0] power_control_reg;
    logic [2:0] divide_select_reg;
    logic [7:0] wake_cfg_reg;
    logic       wr_power_control;
    logic       clear_sleep;
    logic       clear_pdown;
    pmcd_mode_e mode_reg;
    logic [15:0] wake_cnt_reg;

    assign wr_power_control = reg_wr && (reg_addr == PMCD_POWER_CONTROL_ADDR);

    logic idle_wake;
    assign idle_wake = (mode_reg == PMCD_IDLE) &&
                       (enabled_irq || timer_a_irq || timer_b_irq || uart_irq ||
                        |(pins_prev_reg[7:3] & ~pins_s[7:3]));
    assign clear_sleep = idle_wake;
    assign clear_pdown = (mode_reg == PMCD_WAKING) && (wake_cnt_reg == WAKE_LAST);

    // Power control: software bits, hardware flags with set over clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_control_reg <= PMCD_POWER_CONTROL_RESET;
        end else begin
            if (wr_power_control) begin
                power_control_reg <= reg_wdata;
            end
            if (lvd_s) begin
                power_control_reg[PMCD_BIT_LOW_VOLT] <= 1'b1;
            end else if (wr_power_control) begin
                power_control_reg[PMCD_BIT_LOW_VOLT] <= reg_wdata[PMCD_BIT_LOW_VOLT] & power_control_reg[PMCD_BIT_LOW_VOLT];
            end
            if (pon_s) begin
                power_control_reg[PMCD_BIT_POWER_ON] <= 1'b1;
            end else if (wr_power_control) begin
                power_control_reg[PMCD_BIT_POWER_ON] <= reg_wdata[PMCD_BIT_POWER_ON] & power_control_reg[PMCD_BIT_POWER_ON];
            end
            if (clear_sleep && !wr_power_control) begin
                power_control_reg[PMCD_BIT_SLEEP] <= 1'b0;
            end
            if (clear_pdown && !wr_power_control) begin
                power_control_reg[PMCD_BIT_PDOWN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            divide_select_reg <= PMCD_DIVIDE_RESET;
            wake_cfg_reg      <= PMCD_WAKE_ENABLE_RESET;
        end else if (reg_wr && reg_addr == PMCD_SYSTEM_CLOCK_DIVIDER_ADDR) begin
            divide_select_reg <= reg_wdata[2:0];
        end else if (reg_wr && reg_addr == PMCD_WAKE_ENABLE_ADDR) begin
            wake_cfg_reg <= reg_wdata;
        end
    end

    // Read port, unmapped reads as zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                PMCD_POWER_CONTROL_ADDR:        reg_rdata <= power_control_reg;
                PMCD_SYSTEM_CLOCK_DIVIDER_ADDR: reg_rdata <= {5'h00, divide_select_reg};
                PMCD_WAKE_ENABLE_ADDR:          reg_rdata <= wake_cfg_reg;
                default:                        reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Divider: live code only reloads at period end, so no short pulse
    logic [6:0] div_cnt_reg;
    logic [2:0] div_active_reg;
    logic [6:0] div_last;
    logic       div_tick;
    assign div_last = 7'((8'd1 << div_active_reg) - 8'd1);
    assign div_tick = (div_cnt_reg >= div_last);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt_reg    <= 7'h00;
            div_active_reg <= PMCD_DIVIDE_RESET;
        end else if (mode_reg == PMCD_PDOWN || mode_reg == PMCD_WAKING) begin
            div_cnt_reg <= 7'h00;
        end else if (div_tick) begin
            div_cnt_reg    <= 7'h00;
            div_active_reg <= divide_select_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    // Mode sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_reg     <= PMCD_RUN;
            wake_cnt_reg <= 16'h0000;
        end else begin
            unique case (mode_reg)
                PMCD_RUN: begin
                    if (power_control_reg[PMCD_BIT_PDOWN]) begin
                        mode_reg <= PMCD_PDOWN;
                    end else if (power_control_reg[PMCD_BIT_SLEEP]) begin
                        mode_reg <= PMCD_IDLE;
                    end
                end
                PMCD_IDLE: begin
                    if (idle_wake) begin
                        mode_reg <= PMCD_RUN;
                    end
                end
                PMCD_PDOWN: begin
                    wake_cnt_reg <= 16'h0000;
                    if (pin_activity) begin
                        mode_reg <= PMCD_WAKING;
                    end
                end
                PMCD_WAKING: begin
                    if (wake_cnt_reg == WAKE_LAST) begin
                        mode_reg <= PMCD_RUN;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Reset held 24 cycles during idle completes it
    logic [4:0] idle_rst_cnt_reg;
    logic       was_idle_reg;
    always_ff @(posedge ref_clk) begin
        if (rst && was_idle_reg) begin
            if (idle_rst_cnt_reg != IDLE_RST_LAST) begin
                idle_rst_cnt_reg <= idle_rst_cnt_reg + 5'h01;
            end
        end else begin
            idle_rst_cnt_reg <= 5'h00;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst) begin
            was_idle_reg <= (mode_reg == PMCD_IDLE);
        end else if (idle_rst_cnt_reg == IDLE_RST_LAST) begin
            was_idle_reg <= 1'b0;
        end
    end
    assign idle_reset_done = rst && was_idle_reg && (idle_rst_cnt_reg == IDLE_RST_LAST);

    // Clock gates; port levels hold because the CPU clock stops
    always_comb begin
        sys_clk_en          = div_tick && (mode_reg != PMCD_PDOWN) && (mode_reg != PMCD_WAKING);
        gates.cpu_clk_en    = sys_clk_en && (mode_reg == PMCD_RUN) &&
                              !power_control_reg[PMCD_BIT_SLEEP] && !power_control_reg[PMCD_BIT_PDOWN];
        gates.periph_clk_en = sys_clk_en;
        gates.pca_clk_en    = sys_clk_en && ((mode_reg != PMCD_IDLE) ||
                              wake_cfg_reg[PMCD_BIT_PCA_IDLE_RUN]);
        gates.ext_int_active = 1'b1;
    end

    assign uart_baud_doubler  = power_control_reg[PMCD_BIT_BAUD_DBL];
    assign frame_error_select = power_control_reg[PMCD_BIT_FRAME_SEL];
    assign mode               = mode_reg;

    // Assertions
    sequence s_wake_start;
        mode_reg == PMCD_PDOWN && pin_activity;
    endsequence
    sequence s_wake_hold;
        mode_reg == PMCD_WAKING && !sys_clk_en;
    endsequence

    a_pdown_no_clock: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_PDOWN |-> !sys_clk_en && !gates.cpu_clk_en)
        else $error("Clock ran in power-down");
    a_wake_blocked: assert property (@(posedge ref_clk) disable iff (rst)
        s_wake_start |=> s_wake_hold)
        else $error("Clock not blocked after wake");
    a_pin_wake: assert property (@(posedge ref_clk) disable iff (rst)
        s_wake_start |=> mode_reg == PMCD_WAKING)
        else $error("Pin did not wake power-down");
    a_idle_cpu_off: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_IDLE |-> !gates.cpu_clk_en && gates.periph_clk_en == sys_clk_en)
        else $error("Idle gating wrong");
    a_idle_clear: assert property (@(posedge ref_clk) disable iff (rst)
        idle_wake && !wr_power_control |=> !power_control_reg[PMCD_BIT_SLEEP] && mode_reg == PMCD_RUN)
        else $error("Idle not cleared by interrupt");
    a_lvd_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        lvd_s |=> power_control_reg[PMCD_BIT_LOW_VOLT])
        else $error("Low-voltage flag not set");
    a_undivided: assert property (@(posedge ref_clk) disable iff (rst)
        div_active_reg == 3'h0 && mode_reg == PMCD_RUN |-> sys_clk_en)
        else $error("Undivided clock missing pulse");
    a_div_stable: assert property (@(posedge ref_clk) disable iff (rst)
        !div_tick |=> $stable(div_active_reg))
        else $error("Divide code changed mid period");
    a_pca_pause: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_IDLE && !wake_cfg_reg[PMCD_BIT_PCA_IDLE_RUN] |-> !gates.pca_clk_en)
        else $error("Counter array ran in idle");
    a_pca_run: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_IDLE && wake_cfg_reg[PMCD_BIT_PCA_IDLE_RUN] |-> gates.pca_clk_en == sys_clk_en)
        else $error("Counter array stopped in idle");

    // Mode entry and exit
    sequence s_wake_end;
        mode_reg == PMCD_WAKING && wake_cnt_reg == WAKE_LAST && !wr_power_control;
    endsequence
    sequence s_run_again;
        mode_reg == PMCD_RUN && !power_control_reg[PMCD_BIT_PDOWN];
    endsequence

    a_pdown_enter: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_RUN && power_control_reg[PMCD_BIT_PDOWN] |=> mode_reg == PMCD_PDOWN)
        else $error("Power-down not entered");
    a_idle_enter: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_RUN && !power_control_reg[PMCD_BIT_PDOWN] && power_control_reg[PMCD_BIT_SLEEP] |=> mode_reg == PMCD_IDLE)
        else $error("Idle not entered");
    a_idle_by_bit: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(mode_reg == PMCD_IDLE) |-> $past(power_control_reg[PMCD_BIT_SLEEP]))
        else $error("Idle entered without request");
    a_irq_wake: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_IDLE && (timer_a_irq || timer_b_irq || uart_irq || enabled_irq) |=> mode_reg == PMCD_RUN)
        else $error("Interrupt did not end idle");
    a_pdown_hold: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_PDOWN && !pin_activity |=> mode_reg == PMCD_PDOWN)
        else $error("Power-down left without pin");
    a_wake_waits: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg == PMCD_WAKING && wake_cnt_reg != WAKE_LAST |=> mode_reg == PMCD_WAKING)
        else $error("Wake count cut short");
    a_wake_done: assert property (@(posedge ref_clk) disable iff (rst)
        s_wake_end |=> s_run_again)
        else $error("Wake count end not honoured");
    a_cpu_off_modes: assert property (@(posedge ref_clk) disable iff (rst)
        mode_reg != PMCD_RUN |-> !gates.cpu_clk_en)
        else $error("CPU clock ran outside run");

    // Flags, fields and read path
    a_pon_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        pon_s |=> power_control_reg[PMCD_BIT_POWER_ON])
        else $error("Power-on flag not set");
    a_pon_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !pon_s && !wr_power_control |=> $stable(power_control_reg[PMCD_BIT_POWER_ON]))
        else $error("Power-on flag changed by itself");
    a_lvd_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !lvd_s && !wr_power_control |=> $stable(power_control_reg[PMCD_BIT_LOW_VOLT]))
        else $error("Low-voltage flag changed by itself");
    a_flags_store: assert property (@(posedge ref_clk) disable iff (rst)
        wr_power_control |=> power_control_reg[PMCD_BIT_GF1:PMCD_BIT_GF0] == $past(reg_wdata[PMCD_BIT_GF1:PMCD_BIT_GF0]))
        else $error("General flags not stored");
    a_power_control_read: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == PMCD_POWER_CONTROL_ADDR |=> reg_rdata == $past(power_control_reg))
        else $error("Power control read wrong");
    a_baud_follow: assert property (@(posedge ref_clk) disable iff (rst)
        wr_power_control |=> uart_baud_doubler == $past(reg_wdata[PMCD_BIT_BAUD_DBL]))
        else $error("Baud doubler not written");
    a_frame_follow: assert property (@(posedge ref_clk) disable iff (rst)
        wr_power_control |=> frame_error_select == $past(reg_wdata[PMCD_BIT_FRAME_SEL]))
        else $error("Frame select not written");

    // Divider and reset timing
    a_div_reload: assert property (@(posedge ref_clk) disable iff (rst)
        div_tick && (mode_reg == PMCD_RUN || mode_reg == PMCD_IDLE) |=> div_active_reg == $past(divide_select_reg))
        else $error("Divide code not loaded at period end");
    a_div_bound: assert property (@(posedge ref_clk) disable iff (rst)
        div_cnt_reg <= div_last)
        else $error("Divider count past period end");
    a_idle_rst_pulse: assert property (@(posedge ref_clk)
        idle_reset_done |-> $past(rst, 20) ##1 !idle_reset_done)
        else $error("Idle reset done pulse wrong");

endmodule

`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench for the power mode and clock divider block.
 * Assumes pmcd_pkg and the block are compiled first and that one 10 MHz clock drives all.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmcd_pkg::*;
    localparam int WAKE = 16; // Short wake count keeps the run brief
    logic            ref_clk;
    logic            rst;
    logic [7:0]      reg_addr;
    logic [7:0]      reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [7:0]      reg_rdata;
    pmcd_wake_pins_s wake_pins;
    logic [3:0]      irq_v;
    logic            low_voltage_detect;
    logic            power_on_event;
    logic            sys_clk_en;
    pmcd_gates_s     gates;
    logic            uart_baud_doubler;
    logic            frame_error_select;
    logic            idle_reset_done;
    pmcd_mode_e      mode;
    int              bad_count;
    int              tests_run;
    logic [7:0]      rv;
    int              n;

    pmcd_power_mode_clock_divider #(.WAKE_CLOCKS(WAKE)) u_dut (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .wake_pins          (wake_pins),
        .timer_a_irq        (irq_v[0]),
        .timer_b_irq        (irq_v[1]),
        .uart_irq           (irq_v[2]),
        .enabled_irq        (irq_v[3]),
        .low_voltage_detect (low_voltage_detect),
        .power_on_event     (power_on_event),
        .sys_clk_en         (sys_clk_en),
        .gates              (gates),
        .uart_baud_doubler  (uart_baud_doubler),
        .frame_error_select (frame_error_select),
        .idle_reset_done    (idle_reset_done),
        .mode               (mode)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_mode(input pmcd_mode_e m, input int lim, output int cyc);
        cyc = 0;
        while (mode !== m) begin
            @(posedge ref_clk);
            #1;
            cyc++;
            if (cyc > lim) begin
                check("mode wait", {6'h00, mode}, {6'h00, m});
                final_report();
            end
        end
    endtask

    task automatic wait_tick;
        int i;
        i = 0;
        @(negedge ref_clk);
        while (sys_clk_en !== 1'b1) begin
            @(negedge ref_clk);
            i++;
            if (i > 300) begin
                check("tick wait", 8'h00, 8'h01);
                final_report();
            end
        end
    endtask

    task automatic count_ticks(input int cycles, output int cnt);
        cnt = 0;
        repeat (cycles) begin
            @(negedge ref_clk);
            if (sys_clk_en === 1'b1) cnt++;
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wake_pins = 8'hFF;
        irq_v = 4'h0;
        low_voltage_detect = 1'b0;
        power_on_event = 1'b0;
        bad_count = 0;
        tests_run = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd(PMCD_POWER_CONTROL_ADDR, rv); check("power_control", rv, PMCD_POWER_CONTROL_RESET);
        rd(PMCD_SYSTEM_CLOCK_DIVIDER_ADDR, rv); check("clock_divider", rv, 8'h00);
        rd(PMCD_WAKE_ENABLE_ADDR, rv); check("wake_enable", rv, PMCD_WAKE_ENABLE_RESET);
        rd(8'h55, rv); check("unmapped", rv, 8'h00);
        // Writing 0 to the power-on bit clears it
        wr(PMCD_POWER_CONTROL_ADDR, 8'hCC);
        rd(PMCD_POWER_CONTROL_ADDR, rv); check("power_control", rv, 8'hCC);
        check("baud_doubler", {7'h00, uart_baud_doubler}, 8'h01);
        check("frame_select", {7'h00, frame_error_select}, 8'h01);
        wr(PMCD_POWER_CONTROL_ADDR, 8'h00);
        #1;
        check("baud_doubler", {7'h00, uart_baud_doubler}, 8'h00);
        check("frame_select", {7'h00, frame_error_select}, 8'h00);
        @(posedge ref_clk); low_voltage_detect <= 1'b1;
        repeat (4) @(posedge ref_clk); low_voltage_detect <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(PMCD_POWER_CONTROL_ADDR, rv); check("low_voltage", rv, 8'h20);
        wr(PMCD_POWER_CONTROL_ADDR, 8'h00);
        rd(PMCD_POWER_CONTROL_ADDR, rv); check("low_voltage", rv, 8'h00);
        @(posedge ref_clk); power_on_event <= 1'b1;
        repeat (4) @(posedge ref_clk); power_on_event <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(PMCD_POWER_CONTROL_ADDR, rv); check("power_on", rv, 8'h10);
        wr(PMCD_POWER_CONTROL_ADDR, 8'h00);
        rd(PMCD_POWER_CONTROL_ADDR, rv); check("power_on", rv, 8'h00);
        // Every divide code, changed while running
        for (int c = 0; c <= PMCD_DIV_MAX_CODE; c++) begin
            wr(PMCD_SYSTEM_CLOCK_DIVIDER_ADDR, 8'(c));
            repeat (260) @(posedge ref_clk);
            count_ticks(128, n); check("tick_count", 8'(n), 8'(128 >> c));
        end
        wr(PMCD_SYSTEM_CLOCK_DIVIDER_ADDR, 8'hFF);
        rd(PMCD_SYSTEM_CLOCK_DIVIDER_ADDR, rv); check("clock_divider", rv, 8'h07);
        wr(PMCD_SYSTEM_CLOCK_DIVIDER_ADDR, 8'h00);
        // Idle exits: four interrupt levels, then the five idle pins
        for (int k = 0; k < 9; k++) begin
            wr(PMCD_POWER_CONTROL_ADDR, 8'h01);
            wait_mode(PMCD_IDLE, 4, n);
            wait_tick();
            check("cpu_clk_en", {7'h00, gates.cpu_clk_en}, 8'h00);
            check("periph_clk_en", {7'h00, gates.periph_clk_en}, 8'h01);
            @(posedge ref_clk);
            if (k < 4) irq_v <= 4'(1 << k);
            else wake_pins <= ~(8'h80 >> (k - 4));
            wait_mode(PMCD_RUN, 8, n);
            @(posedge ref_clk);
            irq_v <= 4'h0;
            wake_pins <= 8'hFF;
            rd(PMCD_POWER_CONTROL_ADDR, rv); check("sleep_cleared", rv, 8'h00);
            wait_tick(); check("cpu_clk_en", {7'h00, gates.cpu_clk_en}, 8'h01);
        end
        // Counter array pause and run in idle, slowed clock first
        wr(PMCD_SYSTEM_CLOCK_DIVIDER_ADDR, 8'h03);
        wr(PMCD_POWER_CONTROL_ADDR, 8'h01);
        wait_mode(PMCD_IDLE, 4, n);
        wait_tick(); check("pca_clk_en", {7'h00, gates.pca_clk_en}, 8'h00);
        wr(PMCD_WAKE_ENABLE_ADDR, 8'h01);
        wait_tick(); check("pca_clk_en", {7'h00, gates.pca_clk_en}, 8'h01);
        @(posedge ref_clk); irq_v <= 4'h8;
        wait_mode(PMCD_RUN, 8, n);
        @(posedge ref_clk); irq_v <= 4'h0;
        wr(PMCD_SYSTEM_CLOCK_DIVIDER_ADDR, 8'h00);
        // Power-down, woken by each of the eight pins
        for (int k = 0; k < 8; k++) begin
            wr(PMCD_POWER_CONTROL_ADDR, 8'h02);
            wait_mode(PMCD_PDOWN, 4, n);
            count_ticks(16, n); check("pdown_ticks", 8'(n), 8'h00);
            check("ext_int_active", {7'h00, gates.ext_int_active}, 8'h01);
            check("periph_clk_en", {7'h00, gates.periph_clk_en}, 8'h00);
            @(posedge ref_clk); wake_pins <= ~(8'h80 >> k);
            wait_mode(PMCD_WAKING, 8, n);
            wait_mode(PMCD_RUN, WAKE + 4, n); check("wake_cycles", 8'(n), 8'(WAKE));
            @(posedge ref_clk); wake_pins <= 8'hFF;
            rd(PMCD_POWER_CONTROL_ADDR, rv); check("pdown_cleared", rv, 8'h00);
        end
        // Reset while idle, held until idle_reset_done
        wr(PMCD_POWER_CONTROL_ADDR, 8'h01);
        wait_mode(PMCD_IDLE, 4, n);
        @(posedge ref_clk); rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("idle_reset_done", {7'h00, idle_reset_done}, 8'h00);
        n = 3;
        while (idle_reset_done !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("reset_hold_ok", {7'h00, n >= PMCD_IDLE_RESET_CYC - 1 && n <= PMCD_IDLE_RESET_CYC + 1}, 8'h01);
        @(posedge ref_clk); rst <= 1'b0;
        wait_mode(PMCD_RUN, 4, n);
        final_report();
    end
endmodule
`default_nettype wire
